// ### verilog/rtcpt_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtcpt_top
    import rtcpt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [SRC_N-1:0] clk_src_i,
    input wire logic sleep_standby_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic irq_rtc_o,
    output logic irq_pit_o,
    output logic wrap_evt_o,
    output logic cmp_evt_o,
    output logic pit_out_o,
    output logic [EVT_N-1:0] evt_lvl_o
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [SRC_N-1:0] src_sync;
    logic clk_lvl_r, clk_lvl_nxt, tick;
    logic [SRC_W-1:0] src_sel_r, src_sel_nxt;
    logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
    logic [DATA_W-1:0] pctrl_r, pctrl_nxt;
    logic [DATA_W-1:0] ctrl_app_r, ctrl_app_nxt;
    logic [DATA_W-1:0] pctrl_app_r, pctrl_app_nxt;
    logic [CNT_W-1:0] wrap_r, wrap_nxt, wrap_app_r, wrap_app_nxt;
    logic [CNT_W-1:0] cmp_r, cmp_nxt, cmp_app_r, cmp_app_nxt;
    logic [CNT_W-1:0] cnt_wr_r, cnt_wr_nxt;
    logic [DATA_W-1:0] temp_r, temp_nxt;
    logic [1:0] irq_en_r, irq_en_nxt, flag_r, flag_nxt;
    logic pirq_en_r, pirq_en_nxt, pflag_r, pflag_nxt;
    logic [1:0] busy_r [BUSY_N], busy_nxt [BUSY_N];
    logic [BUSY_N-1:0] apply;
    logic load_r, load_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic irq_rtc_nxt, irq_pit_nxt;
    logic [CNT_W-1:0] cnt_val;
    logic wrap_hit, cmp_hit, pit_hit;
    logic core_wrap_evt, core_cmp_evt, core_pit_out;
    logic [EVT_N-1:0] core_evt;

    function automatic logic is_busy(input logic [1:0] b);
        return b != 2'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // timekeeping clock select and edge detect
    rtcpt_sync #(.W(SRC_N)) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i(clk_src_i),
        .q_o(src_sync)
    );

    always_comb begin
        clk_lvl_nxt = src_sync[src_sel_r];
        tick = clk_lvl_nxt && !clk_lvl_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // shared counter core
    rtcpt_core u_core (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .rtc_en_i(ctrl_app_r[EN_BIT]),
        .pit_en_i(pctrl_app_r[EN_BIT]),
        .run_i(!sleep_standby_i || ctrl_app_r[STBY_BIT]),
        .psc_i(ctrl_app_r[PSC_LSB +: PSC_W]),
        .period_i(pctrl_app_r[PSC_LSB +: PSC_W]),
        .wrap_i(wrap_app_r),
        .cmp_i(cmp_app_r),
        .load_i(load_r),
        .load_val_i(cnt_wr_r),
        .cnt_o(cnt_val),
        .wrap_evt_o(core_wrap_evt),
        .cmp_evt_o(core_cmp_evt),
        .wrap_hit_o(wrap_hit),
        .cmp_hit_o(cmp_hit),
        .pit_hit_o(pit_hit),
        .pit_out_o(core_pit_out),
        .evt_lvl_o(core_evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // register writes, sync busy and apply
    always_comb begin
        src_sel_nxt = src_sel_r;
        ctrl_nxt = ctrl_r;
        pctrl_nxt = pctrl_r;
        wrap_nxt = wrap_r;
        cmp_nxt = cmp_r;
        cnt_wr_nxt = cnt_wr_r;
        temp_nxt = temp_r;
        irq_en_nxt = irq_en_r;
        pirq_en_nxt = pirq_en_r;
        flag_nxt = flag_r;
        pflag_nxt = pflag_r;
        for (int i = 0; i < BUSY_N; i++) begin
            apply[i] = tick && (busy_r[i] == 2'h1);
            busy_nxt[i] = (tick && is_busy(busy_r[i])) ? busy_r[i] - 2'h1 : busy_r[i];
        end
        if (wr_i) begin
            unique case (addr_i)
                OFS_CTRL: begin
                    ctrl_nxt = wdata_i;
                    busy_nxt[B_CTRL] = SYNC_TICKS;
                end
                OFS_IRQ_EN: begin
                    irq_en_nxt = wdata_i[1:0];
                end
                OFS_IRQ_FLAG: begin
                    flag_nxt = flag_r & ~wdata_i[1:0];
                end
                OFS_TEMP: begin
                    temp_nxt = wdata_i;
                end
                OFS_SRC: begin
                    src_sel_nxt = wdata_i[SRC_W-1:0];
                end
                OFS_CNT_L, OFS_WRAP_L, OFS_CMP_L: begin
                    temp_nxt = wdata_i;
                end
                OFS_CNT_H: begin
                    cnt_wr_nxt = {wdata_i, temp_r};
                    busy_nxt[B_CNT] = SYNC_TICKS;
                end
                OFS_WRAP_H: begin
                    wrap_nxt = {wdata_i, temp_r};
                    busy_nxt[B_WRAP] = SYNC_TICKS;
                end
                OFS_CMP_H: begin
                    cmp_nxt = {wdata_i, temp_r};
                    busy_nxt[B_CMP] = SYNC_TICKS;
                end
                OFS_PCTRL: begin
                    pctrl_nxt = wdata_i;
                    busy_nxt[B_PCTRL] = SYNC_TICKS;
                end
                OFS_PIRQ_EN: begin
                    pirq_en_nxt = wdata_i[0];
                end
                OFS_PIRQ_FLAG: begin
                    pflag_nxt = pflag_r & ~wdata_i[0];
                end
                default: begin
                end
            endcase
        end
        if (rd_i && (addr_i == OFS_CNT_L)) begin
            temp_nxt = cnt_val[CNT_W-1:DATA_W];
        end
        if (rd_i && (addr_i == OFS_WRAP_L)) begin
            temp_nxt = wrap_r[CNT_W-1:DATA_W];
        end
        if (rd_i && (addr_i == OFS_CMP_L)) begin
            temp_nxt = cmp_r[CNT_W-1:DATA_W];
        end
        // hardware set wins over a clear in the same cycle
        flag_nxt[WRAP_BIT] = flag_nxt[WRAP_BIT] | wrap_hit;
        flag_nxt[CMP_BIT] = flag_nxt[CMP_BIT] | cmp_hit;
        pflag_nxt = pflag_nxt | pit_hit;
        irq_rtc_nxt = |(flag_nxt & irq_en_nxt);
        irq_pit_nxt = pflag_nxt && pirq_en_nxt;
    end

    always_comb begin
        ctrl_app_nxt = apply[B_CTRL] ? ctrl_r : ctrl_app_r;
        pctrl_app_nxt = apply[B_PCTRL] ? pctrl_r : pctrl_app_r;
        wrap_app_nxt = apply[B_WRAP] ? wrap_r : wrap_app_r;
        cmp_app_nxt = apply[B_CMP] ? cmp_r : cmp_app_r;
        load_nxt = apply[B_CNT];
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode
    always_comb begin
        rdata_nxt = '0;
        if (rd_i) begin
            unique case (addr_i)
                OFS_CTRL: rdata_nxt = ctrl_r;
                OFS_STATUS: rdata_nxt = {4'h0, is_busy(busy_r[B_CMP]),
                    is_busy(busy_r[B_WRAP]), is_busy(busy_r[B_CNT]),
                    is_busy(busy_r[B_CTRL])};
                OFS_IRQ_EN: rdata_nxt = {6'h00, irq_en_r};
                OFS_IRQ_FLAG: rdata_nxt = {6'h00, flag_r};
                OFS_TEMP: rdata_nxt = temp_r;
                OFS_SRC: rdata_nxt = {6'h00, src_sel_r};
                OFS_CNT_L: rdata_nxt = cnt_val[DATA_W-1:0];
                OFS_WRAP_L: rdata_nxt = wrap_r[DATA_W-1:0];
                OFS_CMP_L: rdata_nxt = cmp_r[DATA_W-1:0];
                OFS_CNT_H, OFS_WRAP_H, OFS_CMP_H: rdata_nxt = temp_r;
                OFS_PCTRL: rdata_nxt = pctrl_r;
                OFS_PSTAT: rdata_nxt = {7'h00, is_busy(busy_r[B_PCTRL])};
                OFS_PIRQ_EN: rdata_nxt = {7'h00, pirq_en_r};
                OFS_PIRQ_FLAG: rdata_nxt = {7'h00, pflag_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            clk_lvl_r <= 1'b0;
            src_sel_r <= '0;
            ctrl_r <= CTRL_RST;
            pctrl_r <= CTRL_RST;
            ctrl_app_r <= CTRL_RST;
            pctrl_app_r <= CTRL_RST;
            wrap_r <= WRAP_RST;
            wrap_app_r <= WRAP_RST;
            cmp_r <= CMP_RST;
            cmp_app_r <= CMP_RST;
            cnt_wr_r <= '0;
            temp_r <= '0;
            irq_en_r <= '0;
            pirq_en_r <= 1'b0;
            flag_r <= '0;
            pflag_r <= 1'b0;
            for (int i = 0; i < BUSY_N; i++) begin
                busy_r[i] <= 2'h0;
            end
            load_r <= 1'b0;
            rdata_o <= '0;
            irq_rtc_o <= 1'b0;
            irq_pit_o <= 1'b0;
            wrap_evt_o <= 1'b0;
            cmp_evt_o <= 1'b0;
            pit_out_o <= 1'b0;
            evt_lvl_o <= '0;
        end else begin
            clk_lvl_r <= clk_lvl_nxt;
            src_sel_r <= src_sel_nxt;
            ctrl_r <= ctrl_nxt;
            pctrl_r <= pctrl_nxt;
            ctrl_app_r <= ctrl_app_nxt;
            pctrl_app_r <= pctrl_app_nxt;
            wrap_r <= wrap_nxt;
            wrap_app_r <= wrap_app_nxt;
            cmp_r <= cmp_nxt;
            cmp_app_r <= cmp_app_nxt;
            cnt_wr_r <= cnt_wr_nxt;
            temp_r <= temp_nxt;
            irq_en_r <= irq_en_nxt;
            pirq_en_r <= pirq_en_nxt;
            flag_r <= flag_nxt;
            pflag_r <= pflag_nxt;
            for (int i = 0; i < BUSY_N; i++) begin
                busy_r[i] <= busy_nxt[i];
            end
            load_r <= load_nxt;
            rdata_o <= rdata_nxt;
            irq_rtc_o <= irq_rtc_nxt;
            irq_pit_o <= irq_pit_nxt;
            wrap_evt_o <= core_wrap_evt;
            cmp_evt_o <= core_cmp_evt;
            pit_out_o <= core_pit_out;
            evt_lvl_o <= core_evt;
        end
    end
endmodule
`default_nettype wire

// ### verilog/rtcpt_pkg.sv
package rtcpt_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PRE_W = 15;
    localparam int PSC_W = 4;
    localparam int SRC_N = 4;
    localparam int SRC_W = 2;
    localparam int EVT_N = 8;
    localparam int EVT_LO_BIT = 5;
    localparam int BUSY_N = 5;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h01;
    localparam logic [4:0] OFS_IRQ_EN = 5'h02;
    localparam logic [4:0] OFS_IRQ_FLAG = 5'h03;
    localparam logic [4:0] OFS_TEMP = 5'h04;
    localparam logic [4:0] OFS_SRC = 5'h07;
    localparam logic [4:0] OFS_CNT_L = 5'h08;
    localparam logic [4:0] OFS_CNT_H = 5'h09;
    localparam logic [4:0] OFS_WRAP_L = 5'h0A;
    localparam logic [4:0] OFS_WRAP_H = 5'h0B;
    localparam logic [4:0] OFS_CMP_L = 5'h0C;
    localparam logic [4:0] OFS_CMP_H = 5'h0D;
    localparam logic [4:0] OFS_PCTRL = 5'h10;
    localparam logic [4:0] OFS_PSTAT = 5'h11;
    localparam logic [4:0] OFS_PIRQ_EN = 5'h12;
    localparam logic [4:0] OFS_PIRQ_FLAG = 5'h13;

    localparam int EN_BIT = 0;
    localparam int PSC_LSB = 3;
    localparam int STBY_BIT = 7;
    localparam int WRAP_BIT = 0;
    localparam int CMP_BIT = 1;
    localparam int B_CTRL = 0;
    localparam int B_CNT = 1;
    localparam int B_WRAP = 2;
    localparam int B_CMP = 3;
    localparam int B_PCTRL = 4;

    localparam logic [1:0] SYNC_TICKS = 2'h2;
    localparam logic [3:0] PIT_PER_MIN = 4'h1;
    localparam logic [3:0] PIT_PER_MAX = 4'hE;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] WRAP_RST = 16'hFFFF;
    localparam logic [15:0] CMP_RST = 16'h0000;
endpackage

// ### verilog/rtcpt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rtcpt_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### verilog/rtcpt_core.sv
`timescale 1ns/1ps
`default_nettype none
module rtcpt_core
    import rtcpt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic rtc_en_i,
    input wire logic pit_en_i,
    input wire logic run_i,
    input wire logic [PSC_W-1:0] psc_i,
    input wire logic [3:0] period_i,
    input wire logic [CNT_W-1:0] wrap_i,
    input wire logic [CNT_W-1:0] cmp_i,
    input wire logic load_i,
    input wire logic [CNT_W-1:0] load_val_i,
    output logic [CNT_W-1:0] cnt_o,
    output logic wrap_evt_o,
    output logic cmp_evt_o,
    output logic wrap_hit_o,
    output logic cmp_hit_o,
    output logic pit_hit_o,
    output logic pit_out_o,
    output logic [EVT_N-1:0] evt_lvl_o
);
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [CNT_W-1:0] cnt_nxt;
    logic wrap_evt_nxt, cmp_evt_nxt, wrap_hit_nxt, cmp_hit_nxt;
    logic pit_nxt, pit_hit_nxt;
    logic [EVT_N-1:0] evt_nxt;
    logic pre_run, cnt_tick, at_wrap, at_cmp;

    function automatic logic [PRE_W-1:0] psc_mask(input logic [PSC_W-1:0] psc);
        logic [PRE_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < int'(psc)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    always_comb begin
        pre_run = rtc_en_i | pit_en_i;
        pre_nxt = (pre_run && tick_i) ? pre_r + 1'b1 : pre_r;
        cnt_tick = tick_i && rtc_en_i && run_i
            && ((pre_r & psc_mask(psc_i)) == psc_mask(psc_i));
        at_wrap = cnt_tick && (cnt_o == wrap_i);
        at_cmp = cnt_tick && (cnt_o == cmp_i);
        cnt_nxt = cnt_o;
        if (load_i) begin
            cnt_nxt = load_val_i;
        end else if (at_wrap) begin
            cnt_nxt = '0;
        end else if (cnt_tick) begin
            cnt_nxt = cnt_o + 1'b1;
        end
        wrap_hit_nxt = at_wrap;
        cmp_hit_nxt = at_cmp;
        wrap_evt_nxt = tick_i ? at_wrap : wrap_evt_o;
        cmp_evt_nxt = tick_i ? at_cmp : cmp_evt_o;
        pit_nxt = pit_en_i && (period_i >= PIT_PER_MIN) && (period_i <= PIT_PER_MAX)
            && pre_r[period_i];
        pit_hit_nxt = pit_nxt && !pit_out_o;
        evt_nxt = pre_r[EVT_LO_BIT +: EVT_N];
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pre_r <= '0;
            cnt_o <= '0;
            wrap_evt_o <= 1'b0;
            cmp_evt_o <= 1'b0;
            wrap_hit_o <= 1'b0;
            cmp_hit_o <= 1'b0;
            pit_out_o <= 1'b0;
            pit_hit_o <= 1'b0;
            evt_lvl_o <= '0;
        end else begin
            pre_r <= pre_nxt;
            cnt_o <= cnt_nxt;
            wrap_evt_o <= wrap_evt_nxt;
            cmp_evt_o <= cmp_evt_nxt;
            wrap_hit_o <= wrap_hit_nxt;
            cmp_hit_o <= cmp_hit_nxt;
            pit_out_o <= pit_nxt;
            pit_hit_o <= pit_hit_nxt;
            evt_lvl_o <= evt_nxt;
        end
    end
endmodule
`default_nettype wire

// ### sim/rtcpt_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rtcpt_properties
    import rtcpt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic irq_rtc_o,
    input wire logic irq_pit_o,
    input wire logic wrap_evt_o,
    input wire logic cmp_evt_o,
    input wire logic [EVT_N-1:0] evt_lvl_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic rtc_wr;
    logic pit_wr;
    assign rtc_wr = wr_i && (addr_i == OFS_IRQ_FLAG || addr_i == OFS_IRQ_EN);
    assign pit_wr = wr_i && (addr_i == OFS_PIRQ_FLAG || addr_i == OFS_PIRQ_EN);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_wrap_hold;
        wrap_evt_o [*4];
    endsequence
    sequence s_cmp_hold;
        cmp_evt_o [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) == 5'h06 |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_flag_width: assert property ($past(rd_i) && $past(addr_i) == OFS_IRQ_FLAG |-> rdata_o[7:2] == 6'h00)
        else $error("counter flag register has extra bits");
    a_pflag_width: assert property ($past(rd_i) && $past(addr_i) == OFS_PIRQ_FLAG |-> rdata_o[7:1] == 7'h00)
        else $error("periodic flag register has extra bits");
    a_rtc_irq_hold: assert property ($fell(irq_rtc_o) |-> $past(rtc_wr) || $past(rtc_wr, 2))
        else $error("counter irq dropped without software write");
    a_pit_irq_hold: assert property ($fell(irq_pit_o) |-> $past(pit_wr) || $past(pit_wr, 2))
        else $error("periodic irq dropped without software write");
    a_wrap_pulse: assert property ($rose(wrap_evt_o) |-> s_wrap_hold)
        else $error("wrap event shorter than a tick");
    a_cmp_pulse: assert property ($rose(cmp_evt_o) |-> s_cmp_hold)
        else $error("compare event shorter than a tick");
    a_lvl_carry: assert property (((evt_lvl_o[7:1] ^ $past(evt_lvl_o[7:1]))
        & ~($past(evt_lvl_o[6:0]) & ~evt_lvl_o[6:0])) == 7'h00)
        else $error("level event bit moved without carry");
endmodule
bind rtcpt_top rtcpt_properties chk_u (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .irq_rtc_o(irq_rtc_o),
    .irq_pit_o(irq_pit_o),
    .wrap_evt_o(wrap_evt_o),
    .cmp_evt_o(cmp_evt_o),
    .evt_lvl_o(evt_lvl_o)
);
`default_nettype wire

// ### sim/rtcpt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtcpt_top_tb
    import rtcpt_pkg::*;
();
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] clk_src_i = 4'h0;
    logic sleep_standby_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o, evt_lvl_o, div_r = 8'h00, d, e;
    logic irq_rtc_o, irq_pit_o, wrap_evt_o, cmp_evt_o, pit_out_o, p;
    int num_errors = 0, total_checks = 0, n_wrap = 0, n_cmp = 0, m, n;
    logic [4:0] rst_a [10] = '{OFS_CTRL, OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_FLAG, OFS_WRAP_L,
        OFS_WRAP_H, OFS_CMP_L, OFS_PCTRL, OFS_PSTAT, 5'h06};
    logic [7:0] rst_e [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    rtcpt_top dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_src_i(clk_src_i),
        .sleep_standby_i(sleep_standby_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_rtc_o(irq_rtc_o), .irq_pit_o(irq_pit_o),
        .wrap_evt_o(wrap_evt_o), .cmp_evt_o(cmp_evt_o), .pit_out_o(pit_out_o),
        .evt_lvl_o(evt_lvl_o));
    ////////////////////////////////////////////////////////////////////////////
    always #5 clk_sys_i = ~clk_sys_i;
    // timekeeping sources: periods of 8, 16, 32, 64 system clocks
    always @(posedge clk_sys_i) begin
        div_r <= div_r + 8'h01;
        clk_src_i <= div_r[5:2];
    end
    always @(posedge wrap_evt_o) n_wrap++;
    always @(posedge cmp_evt_o) n_cmp++;
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        total_checks++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic idle;
        logic [7:0] s, q;
        for (int k = 0; k < 100; k++) begin
            rd(OFS_STATUS, s);
            rd(OFS_PSTAT, q);
            if ((s | q) === 8'h00) return;
        end
        num_errors++;
        $display("BAD %0t busy flags stuck", $time);
    endtask
    // sync to one change of the watched output, then count cycles to the next
    task automatic gap(input bit s, output int c);
        logic v;
        for (int k = 0; k < 2; k++) begin
            c = 0;
            v = s ? evt_lvl_o[0] : pit_out_o;
            while ((s ? evt_lvl_o[0] : pit_out_o) === v && c < 2000) begin
                @(posedge clk_sys_i);
                #1;
                c++;
            end
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500_000;
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        idle;
        foreach (rst_a[i]) begin
            rd(rst_a[i], d);
            chk(d, rst_e[i]);
        end
        wr(OFS_SRC, 8'h00);
        wr(OFS_WRAP_L, 8'h03);
        wr(OFS_WRAP_H, 8'h00);
        wr(OFS_CMP_L, 8'h02);
        wr(OFS_CMP_H, 8'h00);
        idle;
        wr(OFS_CTRL, 8'h01);
        idle;
        repeat (100) @(posedge clk_sys_i);
        rd(OFS_IRQ_FLAG, d);
        chk(d, 8'h03);
        chk(irq_rtc_o, 1'b0);
        chk(n_wrap > 0 && n_cmp > 0, 1'b1);
        rd(OFS_CNT_L, d);
        chk(d <= 8'h03, 1'b1);
        wr(OFS_IRQ_EN, 8'h03);
        wr(OFS_CTRL, 8'h00);
        idle;
        chk(irq_rtc_o, 1'b1);
        rd(OFS_CNT_L, d);
        m = n_wrap;
        repeat (100) @(posedge clk_sys_i);
        rd(OFS_CNT_L, e);
        chk({e, 16'(n_wrap)}, {d, 16'(m)});
        wr(OFS_IRQ_FLAG, 8'h00);
        rd(OFS_IRQ_FLAG, d);
        chk(d, 8'h03);
        wr(OFS_IRQ_FLAG, 8'h01);
        rd(OFS_IRQ_FLAG, d);
        chk(d, 8'h02);
        wr(OFS_IRQ_FLAG, 8'h02);
        rd(OFS_IRQ_FLAG, d);
        chk({d, 7'h00, irq_rtc_o}, 16'h0000);
        @(posedge clk_sys_i);
        sleep_standby_i <= 1'b1;
        wr(OFS_CTRL, 8'h01);
        idle;
        rd(OFS_CNT_L, d);
        repeat (42) @(posedge clk_sys_i);
        rd(OFS_CNT_L, e);
        chk(e, d);
        wr(OFS_CTRL, 8'h89);
        idle;
        rd(OFS_CNT_L, d);
        repeat (42) @(posedge clk_sys_i);
        rd(OFS_CNT_L, e);
        chk(e != d, 1'b1);
        @(posedge wrap_evt_o);
        n = int'($time);
        @(posedge wrap_evt_o);
        chk(16'(($time - n) / 10), 16'h0040);
        wr(OFS_CTRL, 8'h00);
        idle;
        wr(OFS_PIRQ_EN, 8'h01);
        for (logic [3:0] f = 4'h1; f <= 4'h4; f++) begin
            wr(OFS_PCTRL, {1'b0, f, 3'b001});
            idle;
            gap(1'b0, n);
            chk(n[15:0], 16'(8 << f));
        end
        chk(irq_pit_o, 1'b1);
        wr(OFS_SRC, 8'h01);
        gap(1'b0, n);
        chk(n[15:0], 16'h0100);
        wr(OFS_SRC, 8'h00);
        gap(1'b1, n);
        gap(1'b1, n);
        chk(n[15:0], 16'h0100);
        wr(OFS_PCTRL, 8'h00);
        idle;
        wr(OFS_PIRQ_FLAG, 8'h01);
        rd(OFS_PIRQ_FLAG, d);
        chk({d, 7'h00, irq_pit_o}, 16'h0000);
        e = evt_lvl_o;
        p = pit_out_o;
        repeat (300) @(posedge clk_sys_i);
        chk({evt_lvl_o, pit_out_o}, {e, p});
        give_verdict;
    end
endmodule
`default_nettype wire
